/* core/hps_port.sv */
// Host-port strobe handshake: strobe forming, select latching, wait and bus drive.
// Assumes an internal transfer engine answering with a done pulse, and pins
// that are asynchronous to I_CLOCK.
`timescale 1ns/100ps
module hps_port
  import hps_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  input wire logic I_PORT_CHIP_SELECT_N,
  input wire logic I_DATA_STROBE_ONE,
  input wire logic I_DATA_STROBE_TWO,
  input wire logic I_ADDR_STROBE_N,
  input wire logic [1:0] I_ACCESS_TYPE_CODE,
  input wire logic I_READ_WRITE_SELECT,
  input wire logic I_HALF_WORD_SELECT,
  input wire logic [HPS_DATA_W-1:0] I_HOST_DATA_BUS,
  output logic [HPS_DATA_W-1:0] O_HOST_DATA_BUS,
  output logic O_HOST_DATA_BUS_OE,
  output logic O_HOST_WAIT,
  output logic O_XFER_REQ,
  output logic O_XFER_WRITE,
  output logic [HPS_WORD_W-1:0] O_XFER_WDATA,
  input wire logic I_XFER_DONE,
  input wire logic [HPS_WORD_W-1:0] I_XFER_RDATA,
  output logic O_REG_WR,
  output logic O_REG_SEL_PTR,
  output logic [HPS_DATA_W-1:0] O_REG_WDATA,
  input wire logic [HPS_DATA_W-1:0] I_REG_RDATA
);
  hps_pin_if pins (.clk(I_CLOCK), .rst_n(I_RESETN));
  hps_regs_t q;
  hps_regs_t d;
  logic cs_n_s;
  logic stb_s;
  logic as_n_s;
  hps_sel_t sel_s;
  logic [HPS_DATA_W-1:0] data_s;
  logic is_data;
  logic is_inc;

  assign pins.raw = {I_HOST_DATA_BUS, I_HALF_WORD_SELECT, I_READ_WRITE_SELECT, I_ACCESS_TYPE_CODE,
                     I_ADDR_STROBE_N, I_DATA_STROBE_TWO, I_DATA_STROBE_ONE, I_PORT_CHIP_SELECT_N};

  hps_sync2 u_sync (.pins(pins.syncer));

  assign cs_n_s = pins.sync[HPS_B_CS_N];
  assign stb_s = ~(pins.sync[HPS_B_DS1] ^ pins.sync[HPS_B_DS2]) | cs_n_s;
  assign as_n_s = pins.sync[HPS_B_AS_N];
  assign sel_s = {pins.sync[HPS_B_CODE +: 2], pins.sync[HPS_B_RW], pins.sync[HPS_B_HALF]};
  assign data_s = pins.sync[HPS_B_DATA +: HPS_DATA_W];
  assign is_data = (q.sel.code == HPS_ACC_DATA_INC) || (q.sel.code == HPS_ACC_DATA_FIX);
  assign is_inc = (q.sel.code == HPS_ACC_DATA_INC);

  always_comb
  begin
    d = q;
    d.fetch = 1'b0;
    d.store = 1'b0;
    d.reg_wr = 1'b0;
    d.stb_q = stb_s;
    d.as_q = as_n_s;
    // Latch select group on address strobe if used, else on strobe fall
    if (q.as_q && !as_n_s)
    begin
      d.sel = sel_s;
      d.as_seen = 1'b1;
    end
    else if (q.stb_q && !stb_s && !q.as_seen)
    begin
      d.sel = sel_s;
    end
    case (q.st)
      S_IDLE:
      begin
        if (!stb_s && !q.stb_q && !q.served)
        begin
          d.served = 1'b1;
          if (q.sel.rw)
          begin
            if (is_data && !q.sel.half && !(is_inc && q.pf_valid))
            begin
              d.fetch = 1'b1;
              d.wait_hi = 1'b1;
              d.st = S_FETCH;
            end
            else
            begin
              d.dout = !is_data ? I_REG_RDATA : (q.sel.half ? q.win[31:16] : q.win[15:0]);
              d.oe = 1'b1;
            end
          end
        end
        else if (stb_s && !q.stb_q && q.served)
        begin
          d.served = 1'b0;
          d.as_seen = 1'b0;
          d.oe = 1'b0;
          if (!q.sel.rw)
          begin
            if (!is_data)
            begin
              d.reg_wr = 1'b1;
              d.wdata = {16'h0000, data_s};
            end
            else if (!q.sel.half)
            begin
              d.win[15:0] = data_s;
              d.pf_valid = 1'b0;
            end
            else
            begin
              d.win[31:16] = data_s;
              d.wdata = {data_s, q.win[15:0]};
              d.store = 1'b1;
              d.wait_hi = 1'b1;
              d.busy_rd = 1'b0;
              d.pf_valid = 1'b0;
              d.st = S_BUSY;
            end
          end
          else if (is_inc && q.sel.half)
          begin
            d.fetch = 1'b1;
            d.wait_hi = 1'b1;
            d.busy_rd = 1'b1;
            d.pf_valid = 1'b0;
            d.st = S_BUSY;
          end
        end
      end
      S_FETCH:
      begin
        if (I_XFER_DONE)
        begin
          d.win = I_XFER_RDATA;
          // Only an auto-increment prefetch counts as prefetched
          d.pf_valid = 1'b0;
          d.dout = I_XFER_RDATA[15:0];
          d.oe = 1'b1;
          d.cnt = HPS_LEAD_CYC - 2'h1;
          d.st = S_LEAD;
        end
      end
      S_LEAD:
      begin
        if (q.cnt == 2'h0)
        begin
          d.wait_hi = 1'b0;
          d.st = S_IDLE;
        end
        else
        begin
          d.cnt = q.cnt - 2'h1;
        end
      end
      S_BUSY:
      begin
        if (I_XFER_DONE)
        begin
          if (q.busy_rd)
          begin
            d.win = I_XFER_RDATA;
            d.pf_valid = 1'b1;
          end
          d.wait_hi = 1'b0;
          d.st = S_IDLE;
        end
      end
      default:
      begin
        d.st = S_IDLE;
      end
    endcase
    if (stb_s)
    begin
      d.oe = 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
    begin
      q <= '0;
      q.stb_q <= 1'b1;
      q.as_q <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign O_HOST_WAIT = q.wait_hi & ~cs_n_s;
  assign O_HOST_DATA_BUS = q.dout;
  assign O_HOST_DATA_BUS_OE = q.oe;
  assign O_XFER_REQ = q.fetch | q.store;
  assign O_XFER_WRITE = q.store;
  assign O_XFER_WDATA = q.wdata;
  assign O_REG_WR = q.reg_wr;
  assign O_REG_SEL_PTR = (q.sel.code == HPS_ACC_PTR);
  assign O_REG_WDATA = q.wdata[15:0];

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESETN);

  sequence s_data_out;
    q.oe ##1 q.oe;
  endsequence
  sequence s_wait_drop;
    q.st == S_LEAD ##1 $fell(q.wait_hi);
  endsequence

  a_wait_chip_gate: assert property (cs_n_s |-> !O_HOST_WAIT)
    else $error("wait high while chip select high");
  a_fetch_first_half: assert property ($rose(q.st == S_FETCH) |-> q.fetch && q.sel.rw && !q.sel.half)
    else $error("fetch not tied to first read half");
  a_wait_until_load: assert property (q.st == S_FETCH |-> q.wait_hi ##1 (q.wait_hi || q.st == S_IDLE))
    else $error("wait dropped before window load");
  a_read_lead_time: assert property (s_wait_drop |-> $past(q.oe, 2) && $past(q.st, 2) == S_LEAD)
    else $error("read data did not lead wait release");
  a_store_busy: assert property (q.store |-> q.wait_hi && q.st == S_BUSY && q.sel.half)
    else $error("second half write did not raise wait");
  a_wait_cause: assert property ($rose(q.wait_hi) |-> q.fetch || q.store)
    else $error("wait raised without transfer");
  a_reg_no_wait: assert property (q.reg_wr |-> $stable(q.wait_hi) && !q.wait_hi)
    else $error("register access changed wait");
  a_drive_read_only: assert property (s_data_out |-> !q.stb_q && q.sel.rw)
    else $error("bus driven outside read strobe");
  a_write_capture: assert property (q.store |-> q.wdata[31:16] == $past(data_s))
    else $error("upper half not captured at strobe rise");
endmodule // hps_port

/* core/hps_pkg.sv */
// Shared constants and types of the host-port strobe handshake block.
// Assumes one 100 MHz core clock; all pin inputs arrive asynchronously.
package hps_pkg;
  localparam int HPS_DATA_W = 16;
  localparam int HPS_WORD_W = 32;
  localparam int HPS_PIN_W = 24;
  // Field positions in the raw pin bundle
  localparam int HPS_B_CS_N = 0;
  localparam int HPS_B_DS1 = 1;
  localparam int HPS_B_DS2 = 2;
  localparam int HPS_B_AS_N = 3;
  localparam int HPS_B_CODE = 4;
  localparam int HPS_B_RW = 6;
  localparam int HPS_B_HALF = 7;
  localparam int HPS_B_DATA = 8;
  // Access type codes
  localparam logic [1:0] HPS_ACC_CTRL = 2'h0;
  localparam logic [1:0] HPS_ACC_DATA_INC = 2'h1;
  localparam logic [1:0] HPS_ACC_PTR = 2'h2;
  localparam logic [1:0] HPS_ACC_DATA_FIX = 2'h3;
  // Read data leads the wait release by this many clock periods
  localparam int HPS_CLK_PERIOD_NS = 10;
  localparam int HPS_LEAD_PERIODS = 2;
  localparam int HPS_LEAD_NS = HPS_LEAD_PERIODS * HPS_CLK_PERIOD_NS;
  localparam logic [1:0] HPS_LEAD_CYC = 2'((HPS_LEAD_NS + HPS_CLK_PERIOD_NS - 1) / HPS_CLK_PERIOD_NS);
  localparam logic [HPS_PIN_W-1:0] HPS_PIN_RST = 24'h00000f;

  typedef enum logic [1:0] {S_IDLE, S_FETCH, S_LEAD, S_BUSY} hps_state_t;

  typedef struct packed {
    logic [1:0] code;
    logic rw;
    logic half;
  } hps_sel_t;

  typedef struct packed {
    hps_state_t st;
    logic stb_q;
    logic as_q;
    logic as_seen;
    hps_sel_t sel;
    logic served;
    logic [HPS_WORD_W-1:0] win;
    logic pf_valid;
    logic busy_rd;
    logic [1:0] cnt;
    logic wait_hi;
    logic fetch;
    logic store;
    logic reg_wr;
    logic [HPS_WORD_W-1:0] wdata;
    logic [HPS_DATA_W-1:0] dout;
    logic oe;
  } hps_regs_t;
endpackage

/* core/hps_pin_if.sv */
// Carries the raw host pins and their synchronised copy between modules.
// Assumes the raw bundle is driven straight from device pins.
`timescale 1ns/100ps
interface hps_pin_if
  import hps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n
);
  logic [HPS_PIN_W-1:0] raw;
  logic [HPS_PIN_W-1:0] sync;
  modport syncer (input clk, input rst_n, input raw, output sync);
  modport user (output raw, input sync);
endinterface

/* core/hps_sync2.sv */
// Two-stage synchroniser for the host pin bundle.
// Assumes the pins are asynchronous to the core clock.
`timescale 1ns/100ps
module hps_sync2
  import hps_pkg::*;
(
  hps_pin_if.syncer pins
);
  logic [HPS_PIN_W-1:0] meta_q;
  logic [HPS_PIN_W-1:0] sync_q;

  always_ff @(posedge pins.clk)
  begin
    if (!pins.rst_n)
    begin
      meta_q <= HPS_PIN_RST;
      sync_q <= HPS_PIN_RST;
    end
    else
    begin
      meta_q <= pins.raw;
      sync_q <= meta_q;
    end
  end

  assign pins.sync = sync_q;
endmodule // hps_sync2

/* verif/hps_engine_model.sv */
// Transfer engine model: one stored word, answers each request after a set delay.
// Assumes single-cycle request pulses on the core clock.
`timescale 1ns/100ps
module hps_engine_model
  import hps_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [HPS_WORD_W-1:0] i_wdata,
  input wire logic [5:0] i_delay,
  output logic o_done,
  output logic [HPS_WORD_W-1:0] o_rdata,
  output logic [HPS_WORD_W-1:0] o_mem
);
  logic [5:0] cnt;
  always_ff @(posedge i_clk)
  begin
    o_done <= 1'b0;
    // Read word is only meaningful with done
    o_rdata <= ~o_rdata;
    if (!i_rst_n)
    begin
      cnt <= '0;
      o_mem <= '0;
      o_rdata <= '0;
    end
    else if (i_req)
    begin
      cnt <= i_delay;
      if (i_write)
        o_mem <= i_wdata;
    end
    else if (cnt != 6'h0)
    begin
      cnt <= cnt - 6'h1;
      if (cnt == 6'h1)
      begin
        o_done <= 1'b1;
        o_rdata <= o_mem;
      end
    end
  end
endmodule // hps_engine_model

/* verif/tb.sv */
// Self-checking bench of the host-port handshake, host side driven by tasks.
// Assumes the package, pin interface and design are compiled first.
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb
  import hps_pkg::*;
;
  logic clk, rst_n, cs_n, ds1, ds2, as_n, rw, half;
  logic [1:0] code;
  logic [15:0] hdata, dout, regwd;
  logic [5:0] dly;
  logic oe, hwait, req, xwr, done, regwr, selptr;
  logic [31:0] wdata, rdata, mem;
  int failures, total_checks, reg_wr_n, req_n;

  hps_port hps_port_i (.I_CLOCK(clk), .I_RESETN(rst_n), .I_PORT_CHIP_SELECT_N(cs_n),
    .I_DATA_STROBE_ONE(ds1), .I_DATA_STROBE_TWO(ds2), .I_ADDR_STROBE_N(as_n),
    .I_ACCESS_TYPE_CODE(code), .I_READ_WRITE_SELECT(rw), .I_HALF_WORD_SELECT(half),
    .I_HOST_DATA_BUS(hdata), .O_HOST_DATA_BUS(dout), .O_HOST_DATA_BUS_OE(oe), .O_HOST_WAIT(hwait),
    .O_XFER_REQ(req), .O_XFER_WRITE(xwr), .O_XFER_WDATA(wdata), .I_XFER_DONE(done),
    .I_XFER_RDATA(rdata), .O_REG_WR(regwr), .O_REG_SEL_PTR(selptr), .O_REG_WDATA(regwd),
    .I_REG_RDATA(16'h5a3c));
  hps_engine_model hps_engine_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_write(xwr),
    .i_wdata(wdata), .i_delay(dly), .o_done(done), .o_rdata(rdata), .o_mem(mem));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (regwr === 1'b1) reg_wr_n++;
    if (req === 1'b1) req_n++;
  end

  task automatic test_done;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // One half-word access; select group set a cycle before the strobe falls
  task automatic hs(input logic [1:0] c, input logic r, input logic h, input logic [15:0] d,
                    input int lim, output logic [15:0] rd, output logic wl, output logic wh);
    int n;
    logic [15:0] p1, p2, p3;
    wl = 1'b0;
    wh = 1'b0;
    p1 = '0;
    p2 = '0;
    p3 = '0;
    code = c;
    rw = r;
    half = h;
    hdata = d;
    cyc(1);
    ds2 = 1'b0;
    for (n = 0; n < 60 && (n < 6 || hwait !== 1'b0); n++)
    begin
      cyc(1);
      wl |= hwait;
      p3 = p2;
      p2 = p1;
      p1 = dout;
    end
    if (n == 60) begin failures++; test_done; end
    rd = dout;
    if (r) `CHK(oe, 1'b1)
    if (r && wl) `CHK(p3, rd)
    ds2 = 1'b1;
    for (n = 0; n < lim && (n < 6 || hwait !== 1'b0); n++)
    begin
      cyc(1);
      wh |= hwait;
    end
    if (n == 60) begin failures++; test_done; end
    `CHK(oe, 1'b0)
  endtask

  task automatic sc_gate;
    int n0;
    n0 = reg_wr_n;
    cs_n = 1'b1;
    ds2 = 1'b0;
    cyc(8);
    `CHK(reg_wr_n, n0)
    `CHK(hwait, 1'b0)
    ds2 = 1'b1;
    cs_n = 1'b0;
    cyc(4);
  endtask

  task automatic sc_regs;
    logic [15:0] rd;
    logic wl, wh;
    int n0;
    n0 = reg_wr_n;
    hs(HPS_ACC_PTR, 1'b0, 1'b0, 16'hbeef, 60, rd, wl, wh);
    `CHK({reg_wr_n == n0 + 1, selptr, regwd}, {1'b1, 1'b1, 16'hbeef})
    `CHK({wl, wh}, 2'h0)
    hs(HPS_ACC_CTRL, 1'b1, 1'b0, 16'h0000, 60, rd, wl, wh);
    `CHK({selptr, rd}, {1'b0, 16'h5a3c})
    `CHK({wl, wh}, 2'h0)
  endtask

  task automatic sc_write;
    logic [15:0] rd;
    logic wl, wh;
    hs(HPS_ACC_DATA_INC, 1'b0, 1'b0, 16'h1111, 60, rd, wl, wh);
    `CHK({wl, wh}, 2'h0)
    hs(HPS_ACC_DATA_INC, 1'b0, 1'b1, 16'h2222, 60, rd, wl, wh);
    `CHK(wh, 1'b1)
    `CHK(mem, 32'h22221111)
  endtask

  task automatic sc_read;
    logic [15:0] rd;
    logic wl, wh;
    int n0;
    dly = 6'h7;
    n0 = req_n;
    hs(HPS_ACC_DATA_FIX, 1'b1, 1'b0, 16'h0000, 60, rd, wl, wh);
    `CHK({wl, rd, req_n == n0 + 1}, {1'b1, 16'h1111, 1'b1})
    hs(HPS_ACC_DATA_FIX, 1'b1, 1'b1, 16'h0000, 60, rd, wl, wh);
    `CHK({wl, wh, rd}, {2'h0, 16'h2222})
    hs(HPS_ACC_DATA_INC, 1'b1, 1'b0, 16'h0000, 60, rd, wl, wh);
    `CHK({wl, rd}, {1'b1, 16'h1111})
    hs(HPS_ACC_DATA_INC, 1'b1, 1'b1, 16'h0000, 60, rd, wl, wh);
    `CHK({wh, rd}, {1'b1, 16'h2222})
    n0 = req_n;
    hs(HPS_ACC_DATA_INC, 1'b1, 1'b0, 16'h0000, 60, rd, wl, wh);
    `CHK({wl, rd, req_n == n0}, {1'b0, 16'h1111, 1'b1})
  endtask

  // Address strobe latches the select group; the strobe is formed from the other data strobe
  task automatic sc_astrobe;
    int n0;
    n0 = reg_wr_n;
    code = HPS_ACC_PTR;
    rw = 1'b0;
    half = 1'b0;
    hdata = 16'h0c0d;
    as_n = 1'b0;
    cyc(1);
    ds1 = 1'b0;
    cyc(1);
    as_n = 1'b1;
    code = HPS_ACC_CTRL;
    cyc(5);
    ds1 = 1'b1;
    cyc(6);
    `CHK({reg_wr_n == n0 + 1, selptr, regwd}, {1'b1, 1'b1, 16'h0c0d})
    `CHK(hwait, 1'b0)
  endtask

  task automatic sc_busy;
    logic [15:0] rd;
    logic wl, wh;
    int n;
    dly = 6'h1e;
    hs(HPS_ACC_DATA_INC, 1'b0, 1'b0, 16'h3333, 60, rd, wl, wh);
    hs(HPS_ACC_DATA_INC, 1'b0, 1'b1, 16'h4444, 6, rd, wl, wh);
    cs_n = 1'b1;
    cyc(4);
    `CHK(hwait, 1'b0)
    cs_n = 1'b0;
    cyc(4);
    `CHK(hwait, 1'b1)
    for (n = 0; n < 60 && hwait !== 1'b0; n++)
      cyc(1);
    if (n == 60) begin failures++; test_done; end
    `CHK(mem, 32'h44443333)
  endtask

  initial
  begin
    failures = 0;
    total_checks = 0;
    reg_wr_n = 0;
    req_n = 0;
    cs_n = 1'b1;
    ds1 = 1'b1;
    ds2 = 1'b1;
    as_n = 1'b1;
    rw = 1'b0;
    half = 1'b0;
    code = 2'h0;
    hdata = 16'h0000;
    dly = 6'h3;
    rst_n = 1'b0;
    cyc(4);
    rst_n = 1'b1;
    cs_n = 1'b0;
    cyc(4);
    sc_gate();
    sc_regs();
    sc_astrobe();
    sc_write();
    sc_read();
    sc_busy();
    test_done();
  end
endmodule // tb
